// >>> core/pec_defines.svh
`ifndef PEC_DEFINES_SVH
`define PEC_DEFINES_SVH

// core clock figures
`define PEC_CLK_HZ          25000000
`define PEC_SVC_TIME_NS     14000
// longest service time rounds down to whole cycles
`define PEC_SVC_CYCLES      ((`PEC_SVC_TIME_NS * (`PEC_CLK_HZ / 1000000)) / 1000)
`define PEC_US_CYCLES       (`PEC_CLK_HZ / 1000000)
`define PEC_TICK_DIV        2
`define PEC_DBT_MAX_US      1000000

// register word addresses
`define PEC_ADDR_TICK       16'hF050
`define PEC_ADDR_CAPTURE    16'hF060
`define PEC_PIN_STRIDE_LG   3
`define PEC_FLD_ENABLE      3'h0
`define PEC_FLD_SELECT      3'h1
`define PEC_FLD_OPTIONS     3'h2
`define PEC_FLD_SET_FIRST   3'h3
`define PEC_FLD_SET_SECOND  3'h4
`define PEC_FLD_COUNT       3'h5
`define PEC_FLD_COUNT_CLR   3'h6

// feature selection codes
`define PEC_SEL_PLAIN       32'h0000_0008
`define PEC_SEL_DEBOUNCE    32'h0000_0009

// reset values
`define PEC_RST_WORD        32'h0000_0000

`endif

// >>> core/pec_pkg.sv
package pec_pkg;

  // service engine states
  typedef enum logic [1:0] {
    PEC_IDLE = 2'b01,
    PEC_BUSY = 2'b10
  } pec_state_t;

  // debounce mode codes
  typedef enum logic [2:0] {
    PEC_M_FALL_RST = 3'h0,
    PEC_M_RISE_RST = 3'h1,
    PEC_M_ANY_RST  = 3'h2,
    PEC_M_FALL_FIX = 3'h3,
    PEC_M_RISE_FIX = 3'h4,
    PEC_M_LOW_HOLD = 3'h5,
    PEC_M_HI_HOLD  = 3'h6
  } pec_mode_t;

  // outcome of servicing one edge
  typedef struct packed {
    logic inc;
    logic start;
    logic stop;
    logic clr_exp;
  } pec_act_t;

  // one register access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        strm;
    logic [15:0] addr;
    logic [31:0] wdata;
  } pec_req_t;

endpackage

// >>> core/pec_counter.sv
`timescale 1ns/1ns
// Overview of operation
// - plain selection counts each rising pin edge
// - enable zero turns feature off, one on
// - count read returns count, leaves it unchanged
// - streamed count reads give low 16 bits
// - read-and-clear returns count then zeroes it
// - no update writes accepted by count registers
// - free 32-bit tick timer at half core rate
// - edges of enabled pins outside own service request service
// - edge sets pending flag, service end clears
// - one service completes before next; stream pauses
// - edge in own service lost; edge onto pending overwrites it
// - debounce selection counts applicable polarity edges
// - after count, edges ignored until timeout ends
// - modes 0-2 fall/rise/any, self-restarting timeout
// - modes 3-4 fall/rise only, fixed timeout
// - mode 5 low hold then any edge counts
// - mode 6 high hold then any edge counts
// - restart reloads full configured timeout value
// - second setting selects debounce mode
// - first setting holds timeout in microseconds
`include "pec_defines.svh"
module pec_counter #(
  parameter int NUM_PINS = 4,
  parameter int SVC_CYC  = `PEC_SVC_CYCLES
) (
  input  wire logic                CLK_SYS_I,
  input  wire logic                SRST_I,
  input  wire logic [NUM_PINS-1:0] PIN_I,
  input  wire logic                STREAM_ACTIVE_I,
  input  wire logic                REG_WR_I,
  input  wire logic                REG_RD_I,
  input  wire logic                REG_STREAM_I,
  input  wire logic [15:0]         REG_ADDR_I,
  input  wire logic [31:0]         REG_WDATA_I,
  output logic      [31:0]         REG_RDATA_O,
  output logic                     REG_RVALID_O,
  output logic      [NUM_PINS-1:0] PIN_PENDING_O,
  output logic                     SVC_BUSY_O
);

  localparam int CW = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1;
  localparam int US_CYC = `PEC_US_CYCLES;

  // refuse shapes the address map or timing cannot serve
  initial begin
    if (NUM_PINS < 1 || NUM_PINS > 64) $error("NUM_PINS must be 1..64");
    if (SVC_CYC < 1 || SVC_CYC > 65535) $error("SVC_CYC must be 1..65535");
  end

  pec_pkg::pec_req_t req;                  // bundled access
  assign req = '{wr: REG_WR_I, rd: REG_RD_I, strm: REG_STREAM_I,
                 addr: REG_ADDR_I, wdata: REG_WDATA_I};

  // per-pin configuration and state
  logic [31:0]         en_reg     [NUM_PINS];  // feature enable word
  logic [31:0]         sel_reg    [NUM_PINS];  // feature selection
  logic [31:0]         opt_reg    [NUM_PINS];  // options, held only
  logic [31:0]         first_reg  [NUM_PINS];  // timeout in us
  logic [31:0]         second_reg [NUM_PINS];  // debounce mode
  logic [31:0]         count_reg  [NUM_PINS];  // accumulated count
  logic [19:0]         dbt_reg    [NUM_PINS];  // us left in timeout
  logic [NUM_PINS-1:0] run_reg;                // timeout running
  logic [NUM_PINS-1:0] exp_reg;                // hold-mode timeout expired
  logic [NUM_PINS-1:0] pend_reg;               // pending service flags
  logic [NUM_PINS-1:0] prise_reg;              // polarity of pending edge
  logic [NUM_PINS-1:0] sync1_reg;              // first sync stage
  logic [NUM_PINS-1:0] sync2_reg;              // second sync stage
  logic [NUM_PINS-1:0] last_reg;               // previous synced level
  logic [31:0]         tick_reg;               // free system tick
  logic                tdiv_reg;               // half-rate enable
  logic [4:0]          us_reg;                 // microsecond divider
  logic [15:0]         cap_reg;                // upper half of streamed count
  pec_pkg::pec_state_t st_reg;                 // service engine state
  logic [15:0]         svc_cnt_reg;            // service cycles remaining
  logic [CW-1:0]       svc_ch_reg;             // channel in service
  logic                svc_rise_reg;           // polarity being serviced

  // address decode
  logic          pin_hit;                      // access lands in pin space
  logic [CW-1:0] pin_idx;                      // addressed pin
  logic [2:0]    fld;                          // addressed field
  assign fld     = req.addr[2:0];
  assign pin_idx = CW'(req.addr[15:`PEC_PIN_STRIDE_LG]);
  assign pin_hit = ({3'h0, req.addr[15:`PEC_PIN_STRIDE_LG]} < 16'(NUM_PINS));

  // edge and event wires
  logic [NUM_PINS-1:0] edge_w;                 // any edge on synced pin
  logic                us_tick;                // one-cycle microsecond pulse
  logic                svc_done;               // service finishes this cycle
  logic [CW-1:0]       pick;                   // lowest pending channel
  pec_pkg::pec_act_t   act;                    // result of service

  assign edge_w        = sync2_reg ^ last_reg;
  assign us_tick       = (us_reg == 5'(US_CYC - 1));
  assign svc_done      = (st_reg == pec_pkg::PEC_BUSY) && (svc_cnt_reg == 16'h0001) &&
                         !STREAM_ACTIVE_I;
  assign PIN_PENDING_O = pend_reg;
  assign SVC_BUSY_O    = (st_reg == pec_pkg::PEC_BUSY);

  // true when pin runs one of the serviced counting features
  function automatic logic feat_on(input logic [31:0] en, input logic [31:0] sel);
    feat_on = en[0] && (sel == `PEC_SEL_PLAIN || sel == `PEC_SEL_DEBOUNCE);
  endfunction

  // decide what one serviced edge does to count and timeout
  function automatic pec_pkg::pec_act_t decide(input logic [31:0] sel,
                                                input logic [31:0] mode,
                                                input logic rise,
                                                input logic run,
                                                input logic expd);
    pec_pkg::pec_act_t a;
    a = '0;
    if (sel == `PEC_SEL_PLAIN) begin
      a.inc = rise;
    end else if (mode[31:3] == 29'h0) begin
      case (pec_pkg::pec_mode_t'(mode[2:0]))
        pec_pkg::PEC_M_FALL_RST, pec_pkg::PEC_M_RISE_RST, pec_pkg::PEC_M_ANY_RST: begin
          a.start = 1'b1;
          a.inc   = !run && (mode[1] || (mode[0] == rise));
        end
        pec_pkg::PEC_M_FALL_FIX: begin
          a.inc   = !run && !rise;
          a.start = a.inc;
        end
        pec_pkg::PEC_M_RISE_FIX: begin
          a.inc   = !run && rise;
          a.start = a.inc;
        end
        pec_pkg::PEC_M_LOW_HOLD, pec_pkg::PEC_M_HI_HOLD: begin
          // hold modes: lead polarity arms, the other cancels
          if (expd) begin
            a.inc     = 1'b1;
            a.clr_exp = 1'b1;
          end else if (rise == mode[1]) begin
            a.start   = 1'b1;
          end else begin
            a.stop    = 1'b1;
          end
        end
        default: a = '0;
      endcase
    end
    decide = a;
  endfunction

  assign act = decide(sel_reg[svc_ch_reg], second_reg[svc_ch_reg], svc_rise_reg,
                      run_reg[svc_ch_reg], exp_reg[svc_ch_reg]);

  // lowest-numbered pending channel goes first
  always_comb begin
    pick = '0;
    for (int i = NUM_PINS - 1; i >= 0; i--) begin
      if (pend_reg[i]) pick = CW'(i);
    end
  end

  // two-flop synchroniser and edge history for the pins
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      last_reg  <= '0;
    end else begin
      sync1_reg <= PIN_I;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  // free-running tick at half core rate, plus the us divider
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      tdiv_reg <= 1'b0;
      tick_reg <= '0;
      us_reg   <= '0;
    end else begin
      tdiv_reg <= !tdiv_reg;
      if (tdiv_reg) tick_reg <= tick_reg + 32'h0000_0001;
      us_reg   <= us_tick ? 5'h00 : us_reg + 5'h01;
    end
  end

  // pending flags: every edge on an active pin outside its own service asks for service
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      pend_reg  <= '0;
      prise_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (!feat_on(en_reg[i], sel_reg[i])) begin
          pend_reg[i] <= 1'b0;
        end else if (edge_w[i] &&
                     !(SVC_BUSY_O && svc_ch_reg == CW'(i))) begin
          // a fresh edge overwrites a waiting one; the older is lost
          pend_reg[i]  <= 1'b1;
          prise_reg[i] <= sync2_reg[i];
        end else if (svc_done && svc_ch_reg == CW'(i)) begin
          pend_reg[i]  <= 1'b0;
        end
      end
    end
  end

  // service engine: non-preemptive between channels, stalls for stream
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      st_reg       <= pec_pkg::PEC_IDLE;
      svc_cnt_reg  <= '0;
      svc_ch_reg   <= '0;
      svc_rise_reg <= 1'b0;
    end else begin
      case (st_reg)
        pec_pkg::PEC_IDLE: begin
          if (|pend_reg && !STREAM_ACTIVE_I) begin
            st_reg       <= pec_pkg::PEC_BUSY;
            svc_ch_reg   <= pick;
            svc_rise_reg <= prise_reg[pick];
            svc_cnt_reg  <= 16'(SVC_CYC);
          end
        end
        pec_pkg::PEC_BUSY: begin
          // stream work holds the countdown; others wait their turn
          if (svc_done) begin
            st_reg <= pec_pkg::PEC_IDLE;
          end else if (!STREAM_ACTIVE_I) begin
            svc_cnt_reg <= svc_cnt_reg - 16'h0001;
          end
        end
        default: st_reg <= pec_pkg::PEC_IDLE;
      endcase
    end
  end

  // debounce timers, counted down in microseconds
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      run_reg <= '0;
      exp_reg <= '0;
      for (int i = 0; i < NUM_PINS; i++) dbt_reg[i] <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (!feat_on(en_reg[i], sel_reg[i])) begin
          run_reg[i] <= 1'b0;
          exp_reg[i] <= 1'b0;
        end else if (svc_done && svc_ch_reg == CW'(i) && (act.start || act.stop)) begin
          run_reg[i] <= act.start;
          exp_reg[i] <= 1'b0;
          // clamp oversized settings to the largest legal timeout
          dbt_reg[i] <= (first_reg[i] > `PEC_DBT_MAX_US) ? 20'(`PEC_DBT_MAX_US) :
                        first_reg[i][19:0];
        end else begin
          if (svc_done && svc_ch_reg == CW'(i) && act.clr_exp) exp_reg[i] <= 1'b0;
          if (run_reg[i] && (dbt_reg[i] == 20'h0 || (us_tick && dbt_reg[i] == 20'h1))) begin
            run_reg[i] <= 1'b0;
            // only hold modes remember the expiry for the next edge
            exp_reg[i] <= (second_reg[i] == 32'h5 || second_reg[i] == 32'h6);
          end else if (run_reg[i] && us_tick) begin
            dbt_reg[i] <= dbt_reg[i] - 20'h1;
          end
        end
      end
    end
  end

  // configuration writes; count registers take no writes at all
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        en_reg[i]     <= `PEC_RST_WORD;
        sel_reg[i]    <= `PEC_RST_WORD;
        opt_reg[i]    <= `PEC_RST_WORD;
        first_reg[i]  <= `PEC_RST_WORD;
        second_reg[i] <= `PEC_RST_WORD;
      end
    end else if (req.wr && pin_hit) begin
      case (fld)
        `PEC_FLD_ENABLE:     en_reg[pin_idx]     <= {31'h0, req.wdata[0]};
        `PEC_FLD_SELECT:     sel_reg[pin_idx]    <= req.wdata;
        `PEC_FLD_OPTIONS:    opt_reg[pin_idx]    <= req.wdata;
        `PEC_FLD_SET_FIRST:  first_reg[pin_idx]  <= req.wdata;
        `PEC_FLD_SET_SECOND: second_reg[pin_idx] <= req.wdata;
        default: ;
      endcase
    end
  end

  // counts: serviced increments, read-and-clear zeroes; an edge that
  // completes service in the clear cycle still counts once
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      for (int i = 0; i < NUM_PINS; i++) count_reg[i] <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (req.rd && pin_hit && pin_idx == CW'(i) && fld == `PEC_FLD_COUNT_CLR) begin
          count_reg[i] <= {31'h0, svc_done && svc_ch_reg == CW'(i) && act.inc};
        end else if (svc_done && svc_ch_reg == CW'(i) && act.inc) begin
          count_reg[i] <= count_reg[i] + 32'h0000_0001;
        end
      end
    end
  end

  // read path: one cycle latency, unmapped reads return zero
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      REG_RDATA_O  <= '0;
      REG_RVALID_O <= 1'b0;
      cap_reg      <= '0;
    end else begin
      REG_RVALID_O <= req.rd;
      REG_RDATA_O  <= '0;
      if (req.rd && req.addr == `PEC_ADDR_TICK) begin
        REG_RDATA_O <= tick_reg;
      end else if (req.rd && req.addr == `PEC_ADDR_CAPTURE) begin
        REG_RDATA_O <= {16'h0000, cap_reg};
      end else if (req.rd && pin_hit) begin
        case (fld)
          `PEC_FLD_ENABLE:     REG_RDATA_O <= en_reg[pin_idx];
          `PEC_FLD_SELECT:     REG_RDATA_O <= sel_reg[pin_idx];
          `PEC_FLD_OPTIONS:    REG_RDATA_O <= opt_reg[pin_idx];
          `PEC_FLD_SET_FIRST:  REG_RDATA_O <= first_reg[pin_idx];
          `PEC_FLD_SET_SECOND: REG_RDATA_O <= second_reg[pin_idx];
          `PEC_FLD_COUNT, `PEC_FLD_COUNT_CLR: begin
            if (req.strm) begin
              REG_RDATA_O <= {16'h0000, count_reg[pin_idx][15:0]};
              cap_reg     <= count_reg[pin_idx][31:16];
            end else begin
              REG_RDATA_O <= count_reg[pin_idx];
            end
          end
          default: REG_RDATA_O <= '0;
        endcase
      end
    end
  end

endmodule // pec_counter

// >>> dv/pec_counter_monitor.sv
`timescale 1ns/1ns
// port-level checker for the edge counter; sees only the top ports
module pec_counter_monitor #(
  parameter int NUM_PINS = 4,
  parameter int SVC_CYC  = 8
) (
  input wire logic                CLK_SYS_I,
  input wire logic                SRST_I,
  input wire logic [NUM_PINS-1:0] PIN_I,
  input wire logic                STREAM_ACTIVE_I,
  input wire logic                REG_WR_I,
  input wire logic                REG_RD_I,
  input wire logic                REG_STREAM_I,
  input wire logic [15:0]         REG_ADDR_I,
  input wire logic [31:0]         REG_WDATA_I,
  input wire logic [31:0]         REG_RDATA_O,
  input wire logic                REG_RVALID_O,
  input wire logic [NUM_PINS-1:0] PIN_PENDING_O,
  input wire logic                SVC_BUSY_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);

  int run_cnt; // busy cycles that advanced the service

  // stream cycles do not advance a service, so they are left out of the count
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || !SVC_BUSY_O) begin
      run_cnt <= 0;
    end else if (!STREAM_ACTIVE_I) begin
      run_cnt <= run_cnt + 1;
    end
  end

  property p_rd_answer; REG_RD_I |=> REG_RVALID_O; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read strobe not answered one cycle later");
  property p_no_answer; !REG_RD_I |=> !REG_RVALID_O && REG_RDATA_O == 32'h0; endproperty
  a_no_answer: assert property (p_no_answer)
    else $error("answer without a read");
  property p_strm_low;
    REG_RD_I && REG_STREAM_I && REG_ADDR_I < 16'(NUM_PINS * 8)
      && REG_ADDR_I[2:0] inside {3'h5, 3'h6} |=> REG_RDATA_O[31:16] == 16'h0;
  endproperty
  a_strm_low: assert property (p_strm_low)
    else $error("streamed count read carries upper half");
  property p_svc_len; $fell(SVC_BUSY_O) |-> run_cnt == SVC_CYC; endproperty
  a_svc_len: assert property (p_svc_len)
    else $error("service length differs from configured cycles");
  property p_svc_start;
    $rose(SVC_BUSY_O) |-> !$past(STREAM_ACTIVE_I) && $past(PIN_PENDING_O) != '0;
  endproperty
  a_svc_start: assert property (p_svc_start)
    else $error("service started without a flag or under stream work");
  // limitation: assumes the shortened service is at least eight cycles
  property p_svc_whole; $rose(SVC_BUSY_O) |-> SVC_BUSY_O [*8]; endproperty
  a_svc_whole: assert property (p_svc_whole)
    else $error("service cut short");
  property p_pend_clr;
    |($past(PIN_PENDING_O) & ~PIN_PENDING_O) |-> $past(SVC_BUSY_O) || $past(REG_WR_I, 2);
  endproperty
  a_pend_clr: assert property (p_pend_clr)
    else $error("flag cleared outside service end or write");
  property p_pend_cause;
    (PIN_PENDING_O & ~$past(PIN_PENDING_O) & ~($past(PIN_I, 3) ^ $past(PIN_I, 4))) == '0;
  endproperty
  a_pend_cause: assert property (p_pend_cause)
    else $error("flag raised without a pin edge");
  property p_reset;
    disable iff (1'b0) SRST_I |=> !SVC_BUSY_O && PIN_PENDING_O == '0 && !REG_RVALID_O;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
endmodule // pec_counter_monitor

bind pec_counter pec_counter_monitor #(.NUM_PINS(NUM_PINS), .SVC_CYC(SVC_CYC)) u_mon (
  .CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .PIN_I(PIN_I), .STREAM_ACTIVE_I(STREAM_ACTIVE_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_STREAM_I(REG_STREAM_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
  .REG_RVALID_O(REG_RVALID_O), .PIN_PENDING_O(PIN_PENDING_O), .SVC_BUSY_O(SVC_BUSY_O));

// >>> dv/pec_pulse_src.sv
`timescale 1ns/1ns
// far-side pulse source that owns the counted pin levels
module pec_pulse_src #(
  parameter int NUM_PINS = 4
) (
  input  wire logic                clk_i,
  output logic      [NUM_PINS-1:0] pins_o
);
  initial pins_o = '0; // lines idle low

  // change the masked lines just after a falling edge; some callers place edges
  // inside one service time so that those edges are lost to rate limits
  task automatic set_pins(input logic [NUM_PINS-1:0] m, input logic v);
    @(negedge clk_i);
    pins_o = v ? (pins_o | m) : (pins_o & ~m);
  endtask
endmodule // pec_pulse_src

// >>> dv/pec_counter_tb_top.sv
`timescale 1ns/1ns
`include "pec_defines.svh"
module pec_counter_tb_top;
  localparam int NP = 4; // pins
  localparam int SC = 8; // shortened service length

  logic              clk;        // core clock
  logic              srst;       // sync reset
  logic              strm_act;   // stream work running
  pec_pkg::pec_req_t req;        // register request
  logic [31:0]       rdata;      // read data
  logic              rvalid;     // read answer
  logic              busy;       // service running
  logic [NP-1:0]     pins;       // pin levels
  logic [NP-1:0]     pend;       // pending flags
  logic [31:0]       got;        // last read value
  logic [31:0]       t0;         // first tick sample
  int                err_count;  // mismatches
  int                n_compared; // comparisons
  int                dbx [8] = '{2, 3, 5, 3, 3, 2, 2, 0}; // counts per debounce mode

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  pec_pulse_src #(.NUM_PINS(NP)) u_pec_pulse_src (.clk_i(clk), .pins_o(pins));
  pec_counter #(.NUM_PINS(NP), .SVC_CYC(SC)) u_pec_counter (
    .CLK_SYS_I(clk), .SRST_I(srst), .PIN_I(pins), .STREAM_ACTIVE_I(strm_act),
    .REG_WR_I(req.wr), .REG_RD_I(req.rd), .REG_STREAM_I(req.strm), .REG_ADDR_I(req.addr),
    .REG_WDATA_I(req.wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .PIN_PENDING_O(pend), .SVC_BUSY_O(busy));

  // word address of one field of one pin
  function automatic logic [15:0] ra(input int p, input logic [2:0] f);
    return {10'h0, 3'(p), f};
  endfunction

  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // verdict and end of run
  task automatic results();
    $display("compared=%0d mismatches=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one-cycle write strobe; a fresh falling edge is awaited first
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, strm: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // read strobe, data taken in the answer cycle
  task automatic rd(input logic [15:0] a, input logic s, output logic [31:0] d);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, strm: s, addr: a, wdata: 32'h0};
    @(negedge clk);
    req.rd = 1'b0;
    d = rvalid ? rdata : 32'hDEAD_BEEF;
  endtask

  task automatic rc(input logic [15:0] a, input logic s, input logic [31:0] e);
    rd(a, s, got);
    chk(got, e);
  endtask

  // wait out pin sync, then until all service work is done, bounded
  task automatic settle();
    int n;
    n = 0;
    repeat (4) @(negedge clk);
    while ((busy !== 1'b0 || pend !== '0) && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      chk(32'(pend), 32'h0);
      results();
    end
  endtask

  initial begin
    err_count = 0;
    n_compared = 0;
    srst = 1'b1;
    strm_act = 1'b0;
    req = '0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    // reset value, bit0-only enable, read-only and unmapped places
    rc(ra(3, `PEC_FLD_ENABLE), 1'b0, `PEC_RST_WORD);
    wr(ra(3, `PEC_FLD_ENABLE), 32'hFFFF_FFFF);
    rc(ra(3, `PEC_FLD_ENABLE), 1'b0, 32'h0000_0001);
    wr(ra(3, `PEC_FLD_ENABLE), 32'h0);
    wr(ra(0, `PEC_FLD_COUNT), 32'h0000_0055);
    rc(ra(0, `PEC_FLD_COUNT), 1'b0, 32'h0);
    rc(16'h0100, 1'b0, 32'h0);
    // tick reads twenty cycles apart
    rd(`PEC_ADDR_TICK, 1'b0, t0);
    repeat (18) @(negedge clk);
    rd(`PEC_ADDR_TICK, 1'b0, got);
    chk(got - t0, 32'(20 / `PEC_TICK_DIV));
    for (int p = 0; p < 2; p++) begin
      wr(ra(p, `PEC_FLD_SELECT), `PEC_SEL_PLAIN);
      wr(ra(p, `PEC_FLD_ENABLE), 32'h1);
    end
    // rising edge with stream work pausing the service
    u_pec_pulse_src.set_pins(4'h1, 1'b1);
    repeat (6) @(negedge clk);
    strm_act = 1'b1;
    repeat (5) @(negedge clk);
    strm_act = 1'b0;
    settle();
    rc(ra(0, `PEC_FLD_COUNT), 1'b0, 32'h1);
    // falling edge is serviced but adds nothing
    u_pec_pulse_src.set_pins(4'h1, 1'b0);
    repeat (5) @(negedge clk);
    chk(32'(pend), 32'h1);
    settle();
    rc(ra(0, `PEC_FLD_COUNT), 1'b0, 32'h1);
    // two lines rise together; line 1 falls while line 0 is in service
    u_pec_pulse_src.set_pins(4'h3, 1'b1);
    repeat (5) @(negedge clk);
    u_pec_pulse_src.set_pins(4'h2, 1'b0);
    settle();
    rc(ra(0, `PEC_FLD_COUNT), 1'b0, 32'h2);
    rc(ra(1, `PEC_FLD_COUNT), 1'b0, 32'h0);
    rc(ra(0, `PEC_FLD_COUNT), 1'b1, 32'h2);
    rc(`PEC_ADDR_CAPTURE, 1'b0, 32'h0);
    rc(ra(0, `PEC_FLD_COUNT_CLR), 1'b0, 32'h2);
    rc(ra(0, `PEC_FLD_COUNT), 1'b0, 32'h0);
    // own-channel edges that land during its service are dropped
    u_pec_pulse_src.set_pins(4'h1, 1'b0);
    settle();
    u_pec_pulse_src.set_pins(4'h1, 1'b1);
    repeat (4) @(negedge clk);
    u_pec_pulse_src.set_pins(4'h1, 1'b0);
    u_pec_pulse_src.set_pins(4'h1, 1'b1);
    settle();
    rc(ra(0, `PEC_FLD_COUNT), 1'b0, 32'h1);
    // debounce: slow rise/fall pairs, then a fast rise-fall-rise burst;
    // burst edges sit well inside the 4 us timeout whatever the us phase,
    // slow edges well outside it
    wr(ra(2, `PEC_FLD_SELECT), `PEC_SEL_DEBOUNCE);
    wr(ra(2, `PEC_FLD_SET_FIRST), 32'h4);
    for (int m = 0; m < 8; m++) begin
      wr(ra(2, `PEC_FLD_SET_SECOND), 32'(m));
      wr(ra(2, `PEC_FLD_ENABLE), 32'h1);
      for (int k = 0; k < 7; k++) begin
        u_pec_pulse_src.set_pins(4'h4, (k % 2) == 0);
        repeat ((k == 4 || k == 5) ? 20 : 150) @(negedge clk);
      end
      rc(ra(2, `PEC_FLD_COUNT_CLR), 1'b0, 32'(dbx[m]));
      wr(ra(2, `PEC_FLD_ENABLE), 32'h0);
      u_pec_pulse_src.set_pins(4'h4, 1'b0);
      repeat (20) @(negedge clk);
    end
    // a disabled pin counts nothing
    wr(ra(2, `PEC_FLD_SELECT), `PEC_SEL_PLAIN);
    u_pec_pulse_src.set_pins(4'h4, 1'b1);
    settle();
    rc(ra(2, `PEC_FLD_COUNT), 1'b0, 32'h0);
    results();
  end
endmodule // pec_counter_tb_top
